// File: jtap_tap.sv
/*
  Boundary-scan test access logic: controller, 3-bit instruction
  register and decode, identification, bypass and boundary-scan chain,
  pin multiplexing for test and functional modes.
  Assumes the tester's clock, mode-select, data-in and the system pins
  are asynchronous and much slower than i_sys_clk (tester clock at
  most one fifth of the system clock).
*/
// Overview of operation
// - Three-bit instruction register, shifted LSB first
// - Code 000 puts chain in serial path
// - Capture inputs, shift out, update drives outputs
// - Code 010 scans while pins pass through
// - Preload places pattern on latched outputs
// - Code 001 selects identification register
// - Code 111 bypass adds one clock delay
// - Code 011 holds pins, bypass is path
// - High-impedance code disables all pin outputs
// - Code 101 reserved, tester never loads it
// - Identification register is 32 bits
// - Identification shifted out LSB first
// - Bit0 one, maker, part, version fields
// - Bypass register is exactly one bit
// - Mode-select steers states on test clock
`include "jtap_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module jtap_tap #(
  parameter int          BSC_LEN  = `JTAP_BSC_LEN,    // Chain length
  parameter int          FIFO_DEP = `JTAP_FIFO_DEPTH, // Pattern FIFO depth
  parameter logic [10:0] ID_MFR   = `JTAP_ID_MFR_VAL, // Arbitrary value
  parameter logic [15:0] ID_PRT   = `JTAP_ID_PRT_VAL, // Arbitrary value
  parameter logic [3:0]  ID_VER   = `JTAP_ID_VER_VAL  // Arbitrary value
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset,
  input  wire logic               i_tck,
  input  wire logic               i_tms,
  input  wire logic               i_tdi,
  output logic                    o_tdo,
  output logic                    o_tdo_oe,
  input  wire logic [BSC_LEN-1:0] i_pin_in,
  output logic [BSC_LEN-1:0]      o_pin_out,
  output logic [BSC_LEN-1:0]      o_pin_oe,
  input  wire logic [BSC_LEN-1:0] i_core_out,
  input  wire logic [BSC_LEN-1:0] i_core_oe,
  output logic [BSC_LEN-1:0]      o_core_in,
  output logic [`JTAP_IR_W-1:0]   o_instr
);
  import jtap_pkg::*;

  // Pin synchronisers, first stage read only by second stage
  logic               tck_s1_ff, tck_s2_ff, tck_d_ff;
  logic               tms_s1_ff, tms_s2_ff;
  logic               tdi_s1_ff, tdi_s2_ff;
  logic [BSC_LEN-1:0] pin_s1_ff, pin_s2_ff;

  // Controller and shift registers
  jtap_state_type         state_ff, nxt_state;
  logic [`JTAP_IR_W-1:0]  instruction_shift_register_ff;
  logic [`JTAP_IR_W-1:0]  instr_ff;            // Current instruction
  logic [`JTAP_ID_W-1:0]  identification_register_ff;
  logic                   single_bit_bypass_register_ff;
  logic [BSC_LEN-1:0]     boundary_scan_chain_ff;

  // Update path towards the latched parallel outputs
  logic               pend_ff;                 // Pattern awaits FIFO
  logic [BSC_LEN-1:0] pend_data_ff;
  logic [BSC_LEN-1:0] latch_ff;                // Latched parallel outputs
  logic               tdo_ff, tdo_oe_ff;
  logic [BSC_LEN-1:0] pin_out_ff, pin_oe_ff, core_in_ff;

  wire                fifo_wr_ready;
  wire                fifo_rd_valid;
  wire [BSC_LEN-1:0]  fifo_rd_data;
  wire                fifo_rd_ready;

  // Fixed identification word
  function automatic logic [`JTAP_ID_W-1:0] id_word();
    logic [`JTAP_ID_W-1:0] w;
    w = '0;
    w[`JTAP_ID_FIX_POS] = 1'b1;
    w[`JTAP_ID_MFR_MSB:`JTAP_ID_MFR_LSB] = ID_MFR;
    w[`JTAP_ID_PRT_MSB:`JTAP_ID_PRT_LSB] = ID_PRT;
    w[`JTAP_ID_VER_MSB:`JTAP_ID_VER_LSB] = ID_VER;
    return w;
  endfunction

  // Test clock edges seen from the system clock
  wire tck_rise = tck_s2_ff & ~tck_d_ff;
  wire tck_fall = ~tck_s2_ff & tck_d_ff;

  // Instruction decode
  wire op_extest = (instr_ff == `JTAP_OP_EXTEST);
  wire op_sample = (instr_ff == `JTAP_OP_SAMPLE);
  wire op_idcode = (instr_ff == `JTAP_OP_IDCODE);
  wire op_clamp  = (instr_ff == `JTAP_OP_CLAMP);
  wire op_highz  = (instr_ff == `JTAP_OP_HIGHZ);

  // Serial path; reserved and unassigned codes fall to bypass
  wire jtap_path_type path_sel =
      (op_extest | op_sample) ? PATH_BSC :
      op_idcode               ? PATH_ID  :
                                PATH_BYP;

  // Bit presented at the serial output in each path
  wire dr_out_bit =
      (path_sel == PATH_BSC) ? boundary_scan_chain_ff[0] :
      (path_sel == PATH_ID)  ? identification_register_ff[0] :
                               single_bit_bypass_register_ff;

  // State decode
  wire in_tlr = (state_ff == TS_TLR);
  wire in_cdr = (state_ff == TS_CDR);
  wire in_sdr = (state_ff == TS_SDR);
  wire in_udr = (state_ff == TS_UDR);
  wire in_cir = (state_ff == TS_CIR);
  wire in_sir = (state_ff == TS_SIR);
  wire in_uir = (state_ff == TS_UIR);

  // Pins follow the latched pattern under external test and clamp
  wire drive_bsc = op_extest | op_clamp;

  // Clamp stalls the drain so pins stay unchanged
  assign fifo_rd_ready = ~op_clamp;

  // Synchronisers and edge history
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tck_s1_ff <= 1'b0;
      tck_s2_ff <= 1'b0;
      tck_d_ff  <= 1'b0;
      tms_s1_ff <= 1'b1;
      tms_s2_ff <= 1'b1;
      tdi_s1_ff <= 1'b1;
      tdi_s2_ff <= 1'b1;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      tck_s1_ff <= i_tck;
      tck_s2_ff <= tck_s1_ff;
      tck_d_ff  <= tck_s2_ff;
      tms_s1_ff <= i_tms;
      tms_s2_ff <= tms_s1_ff;
      tdi_s1_ff <= i_tdi;
      tdi_s2_ff <= tdi_s1_ff;
      pin_s1_ff <= i_pin_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Controller next state from mode-select
  always_comb begin
    nxt_state = TS_TLR;
    unique case (state_ff)
      TS_TLR:  nxt_state = tms_s2_ff ? TS_TLR  : TS_RTI;
      TS_RTI:  nxt_state = tms_s2_ff ? TS_SDRS : TS_RTI;
      TS_SDRS: nxt_state = tms_s2_ff ? TS_SIRS : TS_CDR;
      TS_CDR:  nxt_state = tms_s2_ff ? TS_E1DR : TS_SDR;
      TS_SDR:  nxt_state = tms_s2_ff ? TS_E1DR : TS_SDR;
      TS_E1DR: nxt_state = tms_s2_ff ? TS_UDR  : TS_PDR;
      TS_PDR:  nxt_state = tms_s2_ff ? TS_E2DR : TS_PDR;
      TS_E2DR: nxt_state = tms_s2_ff ? TS_UDR  : TS_SDR;
      TS_UDR:  nxt_state = tms_s2_ff ? TS_SDRS : TS_RTI;
      TS_SIRS: nxt_state = tms_s2_ff ? TS_TLR  : TS_CIR;
      TS_CIR:  nxt_state = tms_s2_ff ? TS_E1IR : TS_SIR;
      TS_SIR:  nxt_state = tms_s2_ff ? TS_E1IR : TS_SIR;
      TS_E1IR: nxt_state = tms_s2_ff ? TS_UIR  : TS_PIR;
      TS_PIR:  nxt_state = tms_s2_ff ? TS_E2IR : TS_PIR;
      TS_E2IR: nxt_state = tms_s2_ff ? TS_UIR  : TS_SIR;
      TS_UIR:  nxt_state = tms_s2_ff ? TS_SDRS : TS_RTI;
      // A corrupted one-hot code recovers through reset state
      default: nxt_state = TS_TLR;
    endcase
  end

  // State advances on the rising test clock only
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_ff <= TS_TLR;
    end else if (tck_rise) begin
      state_ff <= nxt_state;
    end
  end

  // Instruction shift stage: capture pattern, then LSB first
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      instruction_shift_register_ff <= `JTAP_IR_CAPTURE;
    end else if (tck_rise && in_cir) begin
      instruction_shift_register_ff <= `JTAP_IR_CAPTURE;
    end else if (tck_rise && in_sir) begin
      instruction_shift_register_ff <=
        {tdi_s2_ff, instruction_shift_register_ff[`JTAP_IR_W-1:1]};
    end
  end

  // Current instruction; reset state forces identification
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || in_tlr) begin
      instr_ff <= `JTAP_OP_IDCODE;
    end else if (tck_fall && in_uir) begin
      instr_ff <= instruction_shift_register_ff;
    end
  end

  // Identification register: load fixed word, shift LSB first
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      identification_register_ff <= '0;
    end else if (tck_rise && in_cdr && path_sel == PATH_ID) begin
      identification_register_ff <= id_word();
    end else if (tck_rise && in_sdr && path_sel == PATH_ID) begin
      identification_register_ff <=
        {tdi_s2_ff, identification_register_ff[`JTAP_ID_W-1:1]};
    end
  end

  // Single-bit bypass: captures zero, one stage of delay
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      single_bit_bypass_register_ff <= 1'b0;
    end else if (tck_rise && in_cdr && path_sel == PATH_BYP) begin
      single_bit_bypass_register_ff <= 1'b0;
    end else if (tck_rise && in_sdr && path_sel == PATH_BYP) begin
      single_bit_bypass_register_ff <= tdi_s2_ff;
    end
  end

  // Boundary-scan chain: capture input pins, shift towards output
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      boundary_scan_chain_ff <= '0;
    end else if (tck_rise && in_cdr && path_sel == PATH_BSC) begin
      boundary_scan_chain_ff <= pin_s2_ff;
    end else if (tck_rise && in_sdr && path_sel == PATH_BSC) begin
      boundary_scan_chain_ff <=
        {tdi_s2_ff, boundary_scan_chain_ff[BSC_LEN-1:1]};
    end
  end

  // Update-DR hands the pattern to the FIFO; new set beats clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pend_ff      <= 1'b0;
      pend_data_ff <= '0;
    end else if (tck_fall && in_udr && path_sel == PATH_BSC) begin
      pend_ff      <= 1'b1;
      pend_data_ff <= boundary_scan_chain_ff;
    end else if (fifo_wr_ready) begin
      pend_ff      <= 1'b0;
    end
  end

  // Latched parallel outputs; frozen while clamp holds the drain
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      latch_ff <= '0;
    end else if (fifo_rd_valid && fifo_rd_ready) begin
      latch_ff <= fifo_rd_data;
    end
  end

  // Serial output changes on the falling test clock
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_ff    <= in_sir ? instruction_shift_register_ff[0] : dr_out_bit;
      tdo_oe_ff <= in_sir | in_sdr;
    end
  end

  // Pin drivers: test pattern, functional pass-through or released
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pin_out_ff <= '0;
      pin_oe_ff  <= '0;
      core_in_ff <= '0;
    end else begin
      pin_out_ff <= drive_bsc ? latch_ff : i_core_out;
      if (op_highz) begin
        pin_oe_ff <= '0;
      end else if (drive_bsc) begin
        pin_oe_ff <= '1;
      end else begin
        pin_oe_ff <= i_core_oe;
      end
      core_in_ff <= pin_s2_ff;
    end
  end

  // Pattern FIFO; a full FIFO holds the pending pattern back
  jtap_fifo #(
    .WIDTH (BSC_LEN),
    .DEPTH (FIFO_DEP)
  ) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_reset    (i_reset),
    .i_wr_valid (pend_ff),
    .o_wr_ready (fifo_wr_ready),
    .i_wr_data  (pend_data_ff),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_rd_ready),
    .o_rd_data  (fifo_rd_data)
  );

  assign o_tdo     = tdo_ff;
  assign o_tdo_oe  = tdo_oe_ff;
  assign o_pin_out = pin_out_ff;
  assign o_pin_oe  = pin_oe_ff;
  assign o_core_in = core_in_ff;
  assign o_instr   = instr_ff;

endmodule

`default_nettype wire

// File: jtap_cfg.svh
/*
  Constants of the boundary-scan test access block: instruction codes,
  identification layout, chain and FIFO sizes.
  Assumes it is included by bare name from the design, checker and bench files.
*/
`ifndef JTAP_CFG_SVH
`define JTAP_CFG_SVH

// Instruction register width and its capture pattern
`define JTAP_IR_W        3
`define JTAP_IR_CAPTURE  3'h1

// Instruction codes
`define JTAP_OP_EXTEST   3'h0
`define JTAP_OP_IDCODE   3'h1
`define JTAP_OP_SAMPLE   3'h2
`define JTAP_OP_CLAMP    3'h3
`define JTAP_OP_HIGHZ    3'h4
`define JTAP_OP_PRODTST  3'h5
`define JTAP_OP_BYPASS   3'h7

// Identification register layout
`define JTAP_ID_W        32
`define JTAP_ID_FIX_POS  0
`define JTAP_ID_MFR_LSB  1
`define JTAP_ID_MFR_MSB  11
`define JTAP_ID_PRT_LSB  12
`define JTAP_ID_PRT_MSB  27
`define JTAP_ID_VER_LSB  28
`define JTAP_ID_VER_MSB  31

// Identity field values: arbitrary, neutral values
`define JTAP_ID_MFR_VAL  11'h2a5
`define JTAP_ID_PRT_VAL  16'h1234
`define JTAP_ID_VER_VAL  4'h1

// Boundary-scan chain length and pattern FIFO depth
`define JTAP_BSC_LEN     16
`define JTAP_FIFO_DEPTH  32

`endif

// File: jtap_pkg.sv
/*
  Types of the boundary-scan test access block: controller states and
  serial path selection.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package jtap_pkg;

  // Test access controller states, one-hot
  typedef enum logic [15:0] {
    TS_TLR  = 16'h0001,  // Test-logic-reset
    TS_RTI  = 16'h0002,  // Run-test/idle
    TS_SDRS = 16'h0004,  // Select-DR-scan
    TS_CDR  = 16'h0008,  // Capture-DR
    TS_SDR  = 16'h0010,  // Shift-DR
    TS_E1DR = 16'h0020,  // Exit1-DR
    TS_PDR  = 16'h0040,  // Pause-DR
    TS_E2DR = 16'h0080,  // Exit2-DR
    TS_UDR  = 16'h0100,  // Update-DR
    TS_SIRS = 16'h0200,  // Select-IR-scan
    TS_CIR  = 16'h0400,  // Capture-IR
    TS_SIR  = 16'h0800,  // Shift-IR
    TS_E1IR = 16'h1000,  // Exit1-IR
    TS_PIR  = 16'h2000,  // Pause-IR
    TS_E2IR = 16'h4000,  // Exit2-IR
    TS_UIR  = 16'h8000   // Update-IR
  } jtap_state_type;

  // Data register placed in the serial path, one-hot
  typedef enum logic [2:0] {
    PATH_BSC = 3'h1,  // Boundary-scan chain
    PATH_ID  = 3'h2,  // Identification register
    PATH_BYP = 3'h4   // Single-bit bypass register
  } jtap_path_type;

endpackage

// File: jtap_fifo.sv
/*
  Pattern FIFO between the boundary-scan update stage and the latched
  parallel outputs. Flip-flop storage, valid/ready on both sides.
  Assumes one clock, synchronous active-high reset, DEPTH a power of two.
*/
`timescale 1ns/1ps
`default_nettype none

module jtap_fifo #(
  parameter int WIDTH = 16,  // Word width
  parameter int DEPTH = 32   // Number of words
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage
  logic [AW:0]      wr_ptr_ff;       // Write pointer, extra wrap bit
  logic [AW:0]      rd_ptr_ff;       // Read pointer, extra wrap bit
  wire              full;
  wire              empty;
  wire              do_wr;
  wire              do_rd;

  // Wrap bit differs with equal index only when full
  assign full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                 (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign do_wr = i_wr_valid & ~full;
  assign do_rd = i_rd_ready & ~empty;

  assign o_wr_ready = ~full;
  assign o_rd_valid = ~empty;
  assign o_rd_data  = mem_ff[rd_ptr_ff[AW-1:0]];

  // Storage write, no reset needed on data
  always_ff @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= i_wr_data;
    end
  end

  // Pointers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: jtap_tap_monitor.sv
/*
  Checker of the boundary-scan access block: port-level timing relations.
  Assumes it is bound to jtap_tap and sees only that module's ports.
*/
`include "jtap_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module jtap_monitor #(
  parameter int BSC_LEN = 16  // Chain length, handed on by the bind
) (
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset,
  input wire logic                  i_tck,
  input wire logic                  i_tms,
  input wire logic                  i_tdi,
  input wire logic                  o_tdo,
  input wire logic                  o_tdo_oe,
  input wire logic [BSC_LEN-1:0]    i_pin_in,
  input wire logic [BSC_LEN-1:0]    o_pin_out,
  input wire logic [BSC_LEN-1:0]    o_pin_oe,
  input wire logic [BSC_LEN-1:0]    i_core_out,
  input wire logic [BSC_LEN-1:0]    i_core_oe,
  input wire logic [BSC_LEN-1:0]    o_core_in,
  input wire logic [`JTAP_IR_W-1:0] o_instr
);
  import jtap_pkg::*;

  // One domain only, so clock and reset are given once
  default clocking mon_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  // First edge after release still shows the reset values
  reset_vals_a: assert property (
    $fell(i_reset) |-> o_instr == 3'h1 && o_pin_oe == '0 && !o_tdo_oe)
    else $error("outputs not at reset values after release");
  // Two cycles settled in high impedance: nothing driven
  highz_off_a: assert property (
    o_instr == 3'h4 [*2] |-> o_pin_oe == '0)
    else $error("pins driven under high impedance");
  // Clamped pins frozen and driven
  clamp_hold_a: assert property (
    o_instr == 3'h3 [*3] |-> $stable(o_pin_out) && o_pin_oe == '1)
    else $error("pins moved while clamped");
  // Non-test codes pass core values with one cycle lag
  pass_thru_a: assert property (
    // Reset forces outputs low, so the edge of release is excluded
    (!i_reset && o_instr inside {3'h1, 3'h2, 3'h6, 3'h7}) [*2]
    |-> o_pin_out == $past(i_core_out) && o_pin_oe == $past(i_core_oe))
    else $error("pins do not follow core logic");
  // External test drives every pin
  extest_drive_a: assert property (
    o_instr == 3'h0 [*2] |-> o_pin_oe == '1)
    else $error("pins not driven under external test");
  // Sample keeps pin inputs reaching the core, three cycles late
  core_feed_a: assert property (
    o_instr == 3'h2 [*4] |-> o_core_in == $past(i_pin_in, 3))
    else $error("core does not see pin inputs");
  // Instruction never changes in the middle of a shift
  instr_update_a: assert property (
    $changed(o_instr) |-> !o_tdo_oe)
    else $error("instruction changed while shifting");
  // Data out is launched only while the test clock is low
  tdo_launch_a: assert property (
    $changed(o_tdo) || $changed(o_tdo_oe) |-> !i_tck)
    else $error("data out changed with test clock high");
endmodule

bind jtap_tap jtap_monitor #(.BSC_LEN(BSC_LEN)) mon_u (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_tck(i_tck),
  .i_tms(i_tms), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .i_core_out(i_core_out), .i_core_oe(i_core_oe),
  .o_core_in(o_core_in), .o_instr(o_instr));

`default_nettype wire

// File: jtap_tester.sv
/*
  Tester model: makes test clock, mode select and data in, samples out.
  Assumes the bench calls shift_bits from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module jtap_tester (
  input  wire logic i_tdo,   // Data out of the device
  output var logic  o_tck,   // Test clock, rests low between frames
  output var logic  o_tms,   // Mode select
  output var logic  o_tdi    // Data in
);
  import jtap_pkg::*;

  // Idle levels at time zero
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  // One 200 ns clock per bit; 7 ns offset keeps edges off system edges
  task automatic shift_bits(input int n, input logic [63:0] tms_v,
                            input logic [63:0] tdi_v,
                            output logic [63:0] tdo_v);
    tdo_v = '0;
    #7;
    for (int i = 0; i < n; i++) begin
      o_tms = tms_v[i];
      o_tdi = tdi_v[i];  // Set up half a period ahead of the rise
      #100;
      o_tck = 1'b1;
      #100;
      tdo_v[i] = i_tdo;  // Stands until this fall
      o_tck = 1'b0;
    end
    o_tdi = ~o_tdi;      // Released line must not keep a stale value
  endtask
endmodule

`default_nettype wire

// File: test_jtap_tap.sv
/*
  Self-checking bench of the boundary-scan access block.
  Assumes the tester model drives the link and the bench the pins.
*/
`include "jtap_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module test_jtap_tap;
  import jtap_pkg::*;
  localparam logic [10:0] MFR_ID = 11'h155;  // Arbitrary value
  localparam logic [15:0] PRT_ID = 16'h0abc; // Arbitrary value
  localparam logic [3:0]  VER_ID = 4'h3;     // Arbitrary value
  localparam logic [31:0] ID_WORD = {VER_ID, PRT_ID, MFR_ID, 1'b1};
  localparam logic [63:0] MASK33  = 64'h1_ffff_ffff;
  localparam logic [63:0] DATA33  = 64'h1_2d3c_4b5a;
  // Expected serial results of a 33-bit scan in each path
  localparam logic [63:0] EXP_BSC = ((DATA33 << 16) | 64'hc35a) & MASK33;
  localparam logic [63:0] EXP_ID  = ((DATA33 << 32) | ID_WORD) & MASK33;
  localparam logic [63:0] EXP_BYP = (DATA33 << 1) & MASK33;

  logic        i_sys_clk;            // System clock
  logic        i_reset;              // Synchronous reset
  logic        tck, tms, tdi;        // Link from tester
  logic        tdo, tdo_oe;          // Link to tester
  wire         tdo_line;             // Data out as the tester sees it
  logic [15:0] pin_in, pin_out;      // System pins
  logic [15:0] pin_oe, core_in;      // Pin enables, core inputs
  logic [15:0] core_out, core_oe;    // Core logic outputs
  logic [2:0]  instr;                // Current instruction
  logic [63:0] junk;                 // Unused serial result
  int          n_fail, checks;       // Verdict counters

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  jtap_tap #(.ID_MFR(MFR_ID), .ID_PRT(PRT_ID), .ID_VER(VER_ID)) dut_u (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_core_out(core_out),
    .i_core_oe(core_oe), .o_core_in(core_in), .o_instr(instr));

  // Undriven line reads inverted, so a late enable shows up as bad data
  assign tdo_line = tdo_oe ? tdo : ~tdo;

  jtap_tester tst_u (.i_tdo(tdo_line), .o_tck(tck), .o_tms(tms),
                     .o_tdi(tdi));

  // Serial and pin compares
  task automatic chk_vec(input logic [63:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [15:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Frame, then let an update settle through pend, FIFO and latch
  task automatic run_bits(input int n, input logic [63:0] tms_v, tdi_v,
                          output logic [63:0] tdo_v);
    tst_u.shift_bits(n, tms_v, tdi_v, tdo_v);
    repeat (8) @(posedge i_sys_clk);
  endtask

  // Idle to idle through the instruction scan, code sent LSB first
  task automatic load_instr(input logic [2:0] code);
    logic [63:0] raw;
    run_bits(9, 64'h0c3, {57'h0, code, 4'h0}, raw);
    chk_vec(raw[6:4], 3'h1, "instruction capture");
    chk_vec(instr, code, "instruction");
  endtask

  // Idle to idle through a data scan of n bits (n at most 59)
  task automatic scan_dr(input int n, input logic [63:0] data,
                         output logic [63:0] out);
    logic [63:0] raw;
    run_bits(n + 5, 64'h1 | (64'h3 << (n + 2)), data << 3, raw);
    out = (raw >> 3) & ((64'h1 << n) - 64'h1);
  endtask

  // Identification selected straight after reset
  task automatic t_idcode;
    logic [63:0] out;
    chk_vec(instr, 3'h1, "instruction after reset");
    scan_dr(32, 64'h0, out);
    chk_vec(out, ID_WORD, "id word");
    $display("test idcode done");
  endtask

  // Serial path length and contents for every permitted code
  task automatic t_paths;
    logic [63:0] out;
    pin_in <= 16'hc35a;
    for (int c = 0; c < 8; c++) begin
      if (c == 5) continue;  // Production code never loaded
      load_instr(c[2:0]);
      scan_dr(33, DATA33, out);
      case (c)
        0: chk_vec(out, EXP_BSC, "extest");
        2: chk_vec(out, EXP_BSC, "sample");
        1: chk_vec(out, EXP_ID, "id");
        default: chk_vec(out, EXP_BYP, "byp");
      endcase
    end
    $display("test paths done");
  endtask

  // Preload, external test, clamp, high impedance, back to bypass
  task automatic t_pins;
    core_out <= 16'h0f0f;
    core_oe  <= 16'h00ff;
    load_instr(3'h2);
    chk_pin(pin_out, 16'h0f0f, "sample out");
    chk_pin(pin_oe, 16'h00ff, "sample oe");
    chk_pin(core_in, 16'hc35a, "core in");
    scan_dr(16, 64'h9669, junk);
    chk_pin(pin_out, 16'h0f0f, "preload undisturbed");
    load_instr(3'h0);
    chk_pin(pin_out, 16'h9669, "preloaded");
    chk_pin(pin_oe, 16'hffff, "extest oe");
    scan_dr(16, 64'h3cc3, junk);
    chk_pin(pin_out, 16'h3cc3, "extest update");
    load_instr(3'h3);
    core_out <= 16'hf0f0;
    scan_dr(16, 64'h0001, junk);
    chk_pin(pin_out, 16'h3cc3, "clamp held");
    load_instr(3'h4);
    chk_pin(pin_oe, 16'h0000, "highz oe");
    load_instr(3'h7);
    chk_pin(pin_out, 16'hf0f0, "bypass out");
    $display("test pins done");
  endtask

  // Reset by pin in mid-run, then by five mode-select highs
  task automatic t_reset;
    i_reset <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    chk_vec(instr, 3'h1, "instruction after pin reset");
    run_bits(1, 64'h0, 64'h0, junk);
    load_instr(3'h7);
    run_bits(6, 64'h1f, 64'h0, junk);
    chk_vec(instr, 3'h1, "instruction after tms reset");
    $display("test reset done");
  endtask

  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset 16 cycles, then to idle and the tests
  initial begin
    i_reset  = 1'b1;
    pin_in   = 16'h0000;
    core_out = 16'h0000;
    core_oe  = 16'h0000;
    n_fail   = 0;
    checks   = 0;
    repeat (16) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    run_bits(1, 64'h0, 64'h0, junk);
    t_idcode;
    t_paths;
    t_pins;
    t_reset;
    stop_test;
  end

  // Whole run needs about 105 us; allow nearly twenty times that
  initial begin
    #2000000;
    n_fail++;
    $display("mismatch at %0t: run did not finish", $time);
    stop_test;
  end
endmodule

`default_nettype wire
